// ===== inc/pll_cfg_defines.vh
// constants for the pll input select, monitor and divider configuration block
// Overview of operation
// - reference predivide 1/2/4/8, oscillator 1/2
// - invert input when its invert bit set
// - invalid after 4 (8 doubled) missing ticks
// - valid after clean validation interval
// - real-time and latched validity per input
// - per-input monitor feedback clock select
// - no switching modes: primary select drives mux
// - pin switching: low primary, high alternate
// - select field picks the switching pin
// - monitor switching: primary while valid, else alternate
// - status shows the selected reference
// - pll runs only while enable is 1
// - feedback ratio scaled by 2^-(33-point)
// - 42-bit feedback divider, 9 integer bits
// - vco integer divide from its field
// - fractional divider runs only when enabled
// - frac divider on vco/2, 2^-(36-point)
// - 40-bit frac divider, 4 integer bits
// - zero divider, zero rem, den 1 is 16.0
`ifndef PLL_CFG_DEFINES_VH
`define PLL_CFG_DEFINES_VH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_INSEL       8'h04
`define OFS_INCFG       8'h08
`define OFS_STATUS      8'h0c
`define OFS_LATCH       8'h10
`define OFS_FBDIV_LO    8'h14
`define OFS_FBDIV_HI    8'h18
`define OFS_FBREM       8'h1c
`define OFS_FBDEN       8'h20
`define OFS_FBMISC      8'h24
`define OFS_FRDIV_LO    8'h28
`define OFS_FRDIV_HI    8'h2c
`define OFS_FRREM       8'h30
`define OFS_FRDEN       8'h34
`define OFS_FRBP        8'h38

// control register fields
`define CTRL_RUN        0
`define CTRL_FRAC_ON    1
`define CTRL_PIN_SW     2
`define CTRL_MON_SW     3
`define CTRL_DOUBLER    4

// input select fields
`define INSEL_PRI_LSB   0
`define INSEL_ALT_LSB   2
`define INSEL_PIN_LSB   4

// per-input config byte fields
`define INCFG_DIV_LSB   0
`define INCFG_INV       2
`define INCFG_MCK       3
`define INCFG_VAL_LSB   4

// status fields
`define STAT_SEL_LSB    4
`define STAT_LOCK       6

// misc fields
`define FBMISC_BP_LSB   0
`define FBMISC_INT_LSB  8

// reset values
`define RST_CTRL        32'h0000_0000
`define RST_INSEL       32'h0000_0000
`define RST_INCFG       32'h0000_0000
`define RST_DEN         32'h0000_0001
`define RST_FBBP        6'h09
`define RST_FRBP        6'h0c
`define RST_VCO_INTEGER_DIVIDE      5'h0c

// fixed-point limits
`define FB_POINT_MAX    6'h21
`define FR_POINT_MAX    6'h24
`define FR_INT_LSB      36

// monitor timing, in feedback clock ticks
`define MISS_LIMIT      4'h4
`define MISS_LIMIT_DBL  4'h8
`define VAL_UNIT        8'h10

`endif

// ===== hdl/pll_cfg.v
// pll input predivide, activity monitors, input mux and divider configuration
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "pll_cfg_defines.vh"

module pll_cfg #(
    parameter NIN    = 4,
    parameter NFB    = 2,
    parameter NGPIO  = 4,
    parameter REM_W  = 32
) (
    // clock and reset
    input  wire                 i_ref_clk,
    input  wire                 i_rstn,
    // axi4-lite write address
    input  wire [7:0]           i_s_awaddr,
    input  wire                 i_s_awvalid,
    output wire                 o_s_awready,
    // axi4-lite write data
    input  wire [31:0]          i_s_wdata,
    input  wire [3:0]           i_s_wstrb,
    input  wire                 i_s_wvalid,
    output wire                 o_s_wready,
    // axi4-lite write response
    output reg  [1:0]           o_s_bresp,
    output reg                  o_s_bvalid,
    input  wire                 i_s_bready,
    // axi4-lite read
    input  wire [7:0]           i_s_araddr,
    input  wire                 i_s_arvalid,
    output wire                 o_s_arready,
    output reg  [31:0]          o_s_rdata,
    output reg  [1:0]           o_s_rresp,
    output reg                  o_s_rvalid,
    input  wire                 i_s_rready,
    // pins: reference inputs (top index is the oscillator), feedback clocks, gpio, lock
    input  wire [NIN-1:0]       i_ref_in,
    input  wire [NFB-1:0]       i_fb_clk,
    input  wire [NGPIO-1:0]     i_gpio,
    input  wire                 i_analog_lock,
    // reference path to the phase detector
    output reg                  o_pll_ref,
    output reg  [1:0]           o_selected_reference,
    output wire [NIN-1:0]       o_input_valid_flag,
    // pll and feedback divider settings
    output wire                 o_pll_run_enable,
    output wire                 o_pll_locked,
    output wire [41:0]          o_fb_divider,
    output wire [REM_W-1:0]     o_feedback_remainder,
    output wire [REM_W-1:0]     o_feedback_denominator,
    output reg  [5:0]           o_fb_frac_shift,
    output wire [4:0]           o_vco_integer_divide,
    // fractional output divider settings
    output wire                 o_frac_out_divider_on,
    output reg  [40:0]          o_frac_out_ratio,
    output wire [REM_W-1:0]     o_frac_out_remainder,
    output wire [REM_W-1:0]     o_frac_out_denominator,
    output reg  [5:0]           o_frac_shift
);

    localparam NP = NIN + NFB + NGPIO + 1;

    // registers
    reg  [31:0]         ctrl_reg;
    reg  [31:0]         insel_reg;
    reg  [31:0]         incfg_reg;
    reg  [NIN-1:0]      latch_reg;
    reg  [41:0]         fbdiv_reg;
    reg  [REM_W-1:0]    fbrem_reg;
    reg  [REM_W-1:0]    fbden_reg;
    reg  [5:0]          fbbp_reg;
    reg  [4:0]          vco_integer_divide_reg;
    reg  [39:0]         frdiv_reg;
    reg  [REM_W-1:0]    frrem_reg;
    reg  [REM_W-1:0]    frden_reg;
    reg  [5:0]          frbp_reg;

    // pin synchronisers
    // three stages; a change is accepted only once stages two and three agree
    reg  [NP-1:0]       sync1_reg;
    reg  [NP-1:0]       sync2_reg;
    reg  [NP-1:0]       sync3_reg;
    reg  [NP-1:0]       pin_reg;
    wire [NP-1:0]       agree;

    assign agree = ~(sync2_reg ^ sync3_reg);

    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1_reg <= {NP{1'b0}};
            sync2_reg <= {NP{1'b0}};
            sync3_reg <= {NP{1'b0}};
            pin_reg   <= {NP{1'b0}};
        end else begin
            sync1_reg <= {i_analog_lock, i_gpio, i_fb_clk, i_ref_in};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_reg   <= (agree & sync3_reg) | (~agree & pin_reg);
        end
    end

    wire [NIN-1:0]      ref_lvl  = pin_reg[NIN-1:0];
    wire [NFB-1:0]      fb_lvl   = pin_reg[NIN+NFB-1:NIN];
    wire [NGPIO-1:0]    gpio_lvl = pin_reg[NIN+NFB+NGPIO-1:NIN+NFB];
    wire                lock_lvl = pin_reg[NP-1];

    // feedback clock ticks: one-cycle pulse on each rising edge
    reg  [NFB-1:0]      fb_prev_reg;
    wire [NFB-1:0]      fb_tick = fb_lvl & ~fb_prev_reg;

    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn)
            fb_prev_reg <= {NFB{1'b0}};
        else
            fb_prev_reg <= fb_lvl;
    end

    // per-input path and monitor
    wire [NIN-1:0]      valid_now;
    wire [NIN-1:0]      valid_chg;
    wire [NIN-1:0]      div_out;
    wire [3:0]          miss_lim = ctrl_reg[`CTRL_DOUBLER] ? `MISS_LIMIT_DBL : `MISS_LIMIT;

    genvar g;
    generate
        for (g = 0; g < NIN; g = g + 1) begin : g_in
            wire [7:0]  cfg  = incfg_reg[8*g+7:8*g];
            wire        lvl  = ref_lvl[g] ^ cfg[`INCFG_INV];
            reg         prev_reg;
            reg  [2:0]  div_reg;
            reg  [3:0]  miss_reg;
            reg  [11:0] good_reg;
            reg         valid_reg;
            wire        edge_seen = lvl & ~prev_reg;
            wire        tick      = fb_tick[cfg[`INCFG_MCK]];
            wire [11:0] good_lim  = {4'h0, `VAL_UNIT} * {8'h00, cfg[7:4]}
                                    + {4'h0, `VAL_UNIT};
            wire        missing   = (miss_reg >= miss_lim);

            always @(posedge i_ref_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    prev_reg  <= 1'b0;
                    div_reg   <= 3'h0;
                    miss_reg  <= 4'h0;
                    good_reg  <= 12'h000;
                    valid_reg <= 1'b0;
                end else begin
                    prev_reg <= lvl;
                    if (edge_seen)
                        div_reg <= div_reg + 3'h1;
                    // a fresh edge restarts the missing-edge count
                    if (edge_seen)
                        miss_reg <= 4'h0;
                    else if (tick && !missing)
                        miss_reg <= miss_reg + 4'h1;
                    if (missing) begin
                        valid_reg <= 1'b0;
                        good_reg  <= 12'h000;
                    end else if (tick && !valid_reg) begin
                        if (good_reg + 12'h001 >= good_lim)
                            valid_reg <= 1'b1;
                        good_reg <= good_reg + 12'h001;
                    end
                end
            end

            // oscillator input only halves; reference inputs take 1/2/4/8
            if (g == NIN - 1) begin : g_osc
                assign div_out[g] = cfg[0] ? div_reg[0] : lvl;
            end else begin : g_ref
                assign div_out[g] = (cfg[1:0] == 2'h0) ? lvl :
                                    div_reg[cfg[1:0] - 2'h1];
            end

            assign valid_now[g] = valid_reg;
            assign valid_chg[g] = valid_reg ^ missing ? 1'b0 :
                                  (missing ? valid_reg
                                           : (tick && !valid_reg
                                              && good_reg + 12'h001 >= good_lim));
        end
    endgenerate

    assign o_input_valid_flag = valid_now;

    // input selection
    wire [1:0]  pri_sel = insel_reg[`INSEL_PRI_LSB+1:`INSEL_PRI_LSB];
    wire [1:0]  alt_sel = insel_reg[`INSEL_ALT_LSB+1:`INSEL_ALT_LSB];
    wire [1:0]  pin_sel = insel_reg[`INSEL_PIN_LSB+1:`INSEL_PIN_LSB];
    reg  [1:0]  sel_next;

    always @* begin
        if (ctrl_reg[`CTRL_PIN_SW])
            sel_next = gpio_lvl[pin_sel] ? alt_sel : pri_sel;
        else if (ctrl_reg[`CTRL_MON_SW])
            sel_next = valid_now[pri_sel] ? pri_sel : alt_sel;
        else
            sel_next = pri_sel;
    end

    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_selected_reference <= 2'h0;
            o_pll_ref            <= 1'b0;
        end else begin
            o_selected_reference <= sel_next;
            o_pll_ref            <= div_out[o_selected_reference];
        end
    end

    // divider settings
    assign o_pll_run_enable       = ctrl_reg[`CTRL_RUN];
    // lock is only meaningful while the loop is running
    assign o_pll_locked           = lock_lvl & ctrl_reg[`CTRL_RUN];
    assign o_fb_divider           = fbdiv_reg;
    assign o_feedback_remainder   = fbrem_reg;
    assign o_feedback_denominator = fbden_reg;
    assign o_vco_integer_divide   = vco_integer_divide_reg;
    assign o_frac_out_divider_on  = ctrl_reg[`CTRL_FRAC_ON] & ctrl_reg[`CTRL_RUN];
    assign o_frac_out_remainder   = frrem_reg;
    assign o_frac_out_denominator = frden_reg;

    // the frac divider input is vco/2 in the analog path; only its ratio is formed here
    wire frac_special = (frdiv_reg == 40'h0) && (frrem_reg == {REM_W{1'b0}})
                        && (frden_reg == {{(REM_W-1){1'b0}}, 1'b1});

    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_fb_frac_shift  <= 6'h00;
            o_frac_shift     <= 6'h00;
            o_frac_out_ratio <= 41'h0;
        end else begin
            o_fb_frac_shift <= `FB_POINT_MAX - fbbp_reg;
            o_frac_shift    <= `FR_POINT_MAX - frbp_reg;
            if (!o_frac_out_divider_on)
                o_frac_out_ratio <= 41'h0;
            else if (frac_special)
                o_frac_out_ratio <= 41'h1 << (`FR_INT_LSB + 4);
            else
                o_frac_out_ratio <= {1'b0, frdiv_reg};
        end
    end

    // axi4-lite slave
    reg         aw_full_reg;
    reg         w_full_reg;
    reg  [7:0]  awaddr_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;
    wire        do_write = aw_full_reg && w_full_reg && !o_s_bvalid;
    wire        wr_ok;
    wire [31:0] clr_mask = (do_write && awaddr_reg == `OFS_LATCH) ?
                           (wdata_reg & {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                                         {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}}) : 32'h0;

    assign o_s_awready = !aw_full_reg && !o_s_bvalid;
    assign o_s_wready  = !w_full_reg && !o_s_bvalid;
    assign o_s_arready = !o_s_rvalid;
    assign wr_ok = (awaddr_reg[1:0] == 2'h0) && (awaddr_reg <= `OFS_FRBP)
                   && (awaddr_reg != `OFS_STATUS);

    function [31:0] merge;
        input [31:0] old;
        input [31:0] d;
        input [3:0]  s;
        integer      k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1)
                if (s[k])
                    merge[8*k +: 8] = d[8*k +: 8];
        end
    endfunction

    wire [31:0] fbhi_new = merge({22'h0, fbdiv_reg[41:32]}, wdata_reg, wstrb_reg);

    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h0;
            wstrb_reg   <= 4'h0;
            o_s_bvalid  <= 1'b0;
            o_s_bresp   <= 2'h0;
            ctrl_reg    <= `RST_CTRL;
            insel_reg   <= `RST_INSEL;
            incfg_reg   <= `RST_INCFG;
            fbdiv_reg   <= 42'h0;
            fbrem_reg   <= {REM_W{1'b0}};
            fbden_reg   <= `RST_DEN;
            fbbp_reg    <= `RST_FBBP;
            vco_integer_divide_reg  <= `RST_VCO_INTEGER_DIVIDE;
            frdiv_reg   <= 40'h0;
            frrem_reg   <= {REM_W{1'b0}};
            frden_reg   <= `RST_DEN;
            frbp_reg    <= `RST_FRBP;
        end else begin
            if (i_s_awvalid && o_s_awready) begin
                aw_full_reg <= 1'b1;
                awaddr_reg  <= i_s_awaddr;
            end
            if (i_s_wvalid && o_s_wready) begin
                w_full_reg <= 1'b1;
                wdata_reg  <= i_s_wdata;
                wstrb_reg  <= i_s_wstrb;
            end
            if (o_s_bvalid && i_s_bready)
                o_s_bvalid <= 1'b0;
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                o_s_bvalid  <= 1'b1;
                o_s_bresp   <= wr_ok ? 2'h0 : 2'h2;
                case (awaddr_reg)
                    `OFS_CTRL:     ctrl_reg  <= merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h1f;
                    `OFS_INSEL:    insel_reg <= merge(insel_reg, wdata_reg, wstrb_reg) & 32'h3f;
                    `OFS_INCFG:    incfg_reg <= merge(incfg_reg, wdata_reg, wstrb_reg);
                    `OFS_FBDIV_LO: fbdiv_reg[31:0] <= merge(fbdiv_reg[31:0], wdata_reg, wstrb_reg);
                    `OFS_FBDIV_HI: fbdiv_reg[41:32] <= fbhi_new[9:0];
                    `OFS_FBREM:    fbrem_reg <= merge(fbrem_reg, wdata_reg, wstrb_reg);
                    `OFS_FBDEN:    fbden_reg <= merge(fbden_reg, wdata_reg, wstrb_reg);
                    `OFS_FBMISC: begin
                        if (wstrb_reg[0])
                            fbbp_reg <= (wdata_reg[5:0] > `FB_POINT_MAX) ?
                                        `FB_POINT_MAX : wdata_reg[5:0];
                        if (wstrb_reg[1])
                            vco_integer_divide_reg <= wdata_reg[12:8];
                    end
                    `OFS_FRDIV_LO: frdiv_reg[31:0] <= merge(frdiv_reg[31:0], wdata_reg, wstrb_reg);
                    `OFS_FRDIV_HI: if (wstrb_reg[0]) frdiv_reg[39:32] <= wdata_reg[7:0];
                    `OFS_FRREM:    frrem_reg <= merge(frrem_reg, wdata_reg, wstrb_reg);
                    `OFS_FRDEN:    frden_reg <= merge(frden_reg, wdata_reg, wstrb_reg);
                    `OFS_FRBP: begin
                        if (wstrb_reg[0])
                            frbp_reg <= (wdata_reg[5:0] > `FR_POINT_MAX) ?
                                        `FR_POINT_MAX : wdata_reg[5:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    // latched validity change: a change in the clearing cycle wins over the clear
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn)
            latch_reg <= {NIN{1'b0}};
        else
            latch_reg <= (latch_reg & ~clr_mask[NIN-1:0]) | valid_chg;
    end

    // read side answers one cycle after the address is taken
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0;
        case (i_s_araddr)
            `OFS_CTRL:     rd_mux = ctrl_reg;
            `OFS_INSEL:    rd_mux = insel_reg;
            `OFS_INCFG:    rd_mux = incfg_reg;
            `OFS_STATUS:   rd_mux = {25'h0, o_pll_locked, o_selected_reference, valid_now};
            `OFS_LATCH:    rd_mux = {{(32-NIN){1'b0}}, latch_reg};
            `OFS_FBDIV_LO: rd_mux = fbdiv_reg[31:0];
            `OFS_FBDIV_HI: rd_mux = {22'h0, fbdiv_reg[41:32]};
            `OFS_FBREM:    rd_mux = fbrem_reg;
            `OFS_FBDEN:    rd_mux = fbden_reg;
            `OFS_FBMISC:   rd_mux = {19'h0, vco_integer_divide_reg, 2'h0, fbbp_reg};
            `OFS_FRDIV_LO: rd_mux = frdiv_reg[31:0];
            `OFS_FRDIV_HI: rd_mux = {24'h0, frdiv_reg[39:32]};
            `OFS_FRREM:    rd_mux = frrem_reg;
            `OFS_FRDEN:    rd_mux = frden_reg;
            `OFS_FRBP:     rd_mux = {26'h0, frbp_reg};
            default:       rd_mux = 32'h0;
        endcase
    end

    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_s_rvalid <= 1'b0;
            o_s_rdata  <= 32'h0;
            o_s_rresp  <= 2'h0;
        end else if (i_s_arvalid && !o_s_rvalid) begin
            o_s_rvalid <= 1'b1;
            o_s_rdata  <= rd_mux;
            o_s_rresp  <= ((i_s_araddr[1:0] == 2'h0) && (i_s_araddr <= `OFS_FRBP)) ?
                          2'h0 : 2'h2;
        end else if (o_s_rvalid && i_s_rready) begin
            o_s_rvalid <= 1'b0;
        end
    end

endmodule // pll_cfg

// ===== verification/pll_cfg_chk.sv
// concurrent checks on the ports of the pll configuration block
`timescale 1ns/1ps
module pll_cfg_chk (
    // clock and reset
    input wire        i_ref_clk,
    input wire        i_rstn,
    // register bus
    input wire        o_s_awready,
    input wire        o_s_wready,
    input wire        o_s_bvalid,
    input wire [1:0]  o_s_bresp,
    input wire        i_s_bready,
    input wire        i_s_arvalid,
    input wire        o_s_arready,
    input wire        o_s_rvalid,
    input wire [31:0] o_s_rdata,
    input wire        i_s_rready,
    // pll status and settings
    input wire        i_analog_lock,
    input wire        o_pll_run_enable,
    input wire        o_pll_locked,
    input wire        o_frac_out_divider_on,
    input wire [40:0] o_frac_out_ratio,
    input wire [5:0]  o_fb_frac_shift,
    input wire [5:0]  o_frac_shift
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    AST_B_HOLD: assert property (o_s_bvalid && !i_s_bready |=> o_s_bvalid && $stable(o_s_bresp))
        else $error("write response dropped or changed early");
    AST_R_HOLD: assert property (o_s_rvalid && !i_s_rready |=> o_s_rvalid && $stable(o_s_rdata))
        else $error("read data dropped or changed early");
    AST_REFUSE: assert property (o_s_bvalid |-> !o_s_awready && !o_s_wready)
        else $error("write accepted while response pending");
    AST_AR_ANS: assert property (i_s_arvalid && o_s_arready |=> o_s_rvalid)
        else $error("read answer late");
    AST_LOCK_RUN: assert property (o_pll_locked |-> o_pll_run_enable)
        else $error("lock shown while pll stopped");
    AST_LOCK_ON: assert property ((i_analog_lock && o_pll_run_enable) [*8] |-> o_pll_locked)
        else $error("lock not shown");
    AST_FR_OFF: assert property ((!o_frac_out_divider_on) [*2] |-> o_frac_out_ratio == 41'h0)
        else $error("fractional divider active while off");
    AST_FB_SHIFT: assert property (o_fb_frac_shift <= 6'd33)
        else $error("feedback shift out of range");
    AST_FR_SHIFT: assert property (o_frac_shift <= 6'd36)
        else $error("fractional shift out of range");
endmodule // pll_cfg_chk

bind pll_cfg pll_cfg_chk u_chk (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .o_s_awready(o_s_awready),
    .o_s_wready(o_s_wready), .o_s_bvalid(o_s_bvalid), .o_s_bresp(o_s_bresp),
    .i_s_bready(i_s_bready), .i_s_arvalid(i_s_arvalid), .o_s_arready(o_s_arready),
    .o_s_rvalid(o_s_rvalid), .o_s_rdata(o_s_rdata), .i_s_rready(i_s_rready),
    .i_analog_lock(i_analog_lock), .o_pll_run_enable(o_pll_run_enable),
    .o_pll_locked(o_pll_locked), .o_frac_out_divider_on(o_frac_out_divider_on),
    .o_frac_out_ratio(o_frac_out_ratio), .o_fb_frac_shift(o_fb_frac_shift),
    .o_frac_shift(o_frac_shift)
);

// ===== verification/ref_clk_src.sv
// reference and feedback clock sources with an analog lock indication
`timescale 1ns/1ps
module ref_clk_src (
    // control from the bench and the block
    input  wire       i_run,
    input  wire [3:0] i_stop,
    // clocks and lock toward the block
    output reg  [3:0] o_ref,
    output reg  [1:0] o_fb,
    output reg        o_lock
);
    initial begin
        o_ref = 4'h0;
        o_fb = 2'h0;
        o_lock = 1'b0;
    end
    // one shared reference rate keeps all inputs at a common detector rate
    always #150 o_ref = ~o_ref & ~i_stop;
    always #200 o_fb = ~o_fb;
    // lock arrives late, as a real loop needs time to settle
    always @(posedge i_run) #2000 o_lock = i_run;
    always @(negedge i_run) o_lock = 1'b0;
endmodule // ref_clk_src

// ===== verification/pll_cfg_tb_top.sv
// self-checking bench for the pll configuration block
`timescale 1ns/1ps
module pll_cfg_tb_top;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, s_rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        lock, run, pref, frac_on, locked, awrdy, wrdy, bvalid, arrdy, rvalid;
    logic [3:0]  gpio = 4'h0, stop = 4'h0, ref_in, vflag;
    logic [1:0]  fb, sel, resp, bresp, rresp;
    logic [41:0] fbdiv;
    logic [31:0] fbrem, fbden, frrem, frden;
    logic [40:0] fratio;
    logic [5:0]  fbsh, frsh;
    logic [4:0]  vco_integer_divide;
    integer      miscompares = 0, n_tests = 0, edges = 0, k;

    always #12.5 clk = ~clk;
    always @(posedge pref) edges++;

    ref_clk_src u_src (.i_run(run), .i_stop(stop), .o_ref(ref_in), .o_fb(fb), .o_lock(lock));

    pll_cfg u_dut (
        .i_ref_clk(clk), .i_rstn(rstn), .i_s_awaddr(awaddr), .i_s_awvalid(awvalid),
        .o_s_awready(awrdy), .i_s_wdata(wdata), .i_s_wstrb(4'hf), .i_s_wvalid(wvalid),
        .o_s_wready(wrdy), .o_s_bresp(bresp), .o_s_bvalid(bvalid), .i_s_bready(bready),
        .i_s_araddr(araddr), .i_s_arvalid(arvalid), .o_s_arready(arrdy),
        .o_s_rdata(s_rdata), .o_s_rresp(rresp), .o_s_rvalid(rvalid), .i_s_rready(rready),
        .i_ref_in(ref_in), .i_fb_clk(fb), .i_gpio(gpio), .i_analog_lock(lock),
        .o_pll_ref(pref), .o_selected_reference(sel), .o_input_valid_flag(vflag),
        .o_pll_run_enable(run), .o_pll_locked(locked), .o_fb_divider(fbdiv),
        .o_feedback_remainder(fbrem), .o_feedback_denominator(fbden), .o_fb_frac_shift(fbsh),
        .o_vco_integer_divide(vco_integer_divide), .o_frac_out_divider_on(frac_on),
        .o_frac_out_ratio(fratio), .o_frac_out_remainder(frrem), .o_frac_out_denominator(frden),
        .o_frac_shift(frsh)
    );

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // the extra edge at the end lets settings derived from the register land
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awrdy) awvalid <= 1'b0;
            if (wrdy) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arrdy) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rdata = s_rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #400000;
        miscompares++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h24);
        chk("fbmisc reset", 32'h0000_0c09, rdata);
        wr(8'h00, 32'h1);
        for (k = 0; k < 4; k++) begin
            wr(8'h08, k);
            repeat (40) @(posedge clk);
            edges = 0;
            repeat (960) @(posedge clk);
            chk("predivide", 1, edges >= (80 >> k) - 1 && edges <= (80 >> k) + 1);
        end
        chk("locked", 1, locked);
        wr(8'h04, 32'h39);
        repeat (10) @(posedge clk);
        chk("sel register", 1, sel);
        gpio <= 4'h8;
        wr(8'h00, 32'h5);
        repeat (10) @(posedge clk);
        chk("sel pin high", 2, sel);
        gpio <= 4'h7;
        repeat (10) @(posedge clk);
        chk("sel pin low", 1, sel);
        wr(8'h10, 32'hf);
        wr(8'h00, 32'h19);
        stop <= 4'h2;
        repeat (88) @(posedge clk);
        rd(8'h0c);
        chk("valid doubled", 4'hf, rdata[3:0]);
        repeat (60) @(posedge clk);
        chk("sel monitor", 2, sel);
        rd(8'h0c);
        chk("valid now", 4'hd, rdata[3:0]);
        chk("valid flag", 4'hd, vflag);
        rd(8'h10);
        chk("latched", 4'h2, rdata[3:0]);
        wr(8'h10, 32'h2);
        rd(8'h10);
        chk("latch clear", 0, rdata[3:0]);
        wr(8'h00, 32'h1);
        wr(8'h08, 32'h400);
        repeat (10) @(posedge clk);
        chk("invert", 1, pref);
        wr(8'h00, 32'h9);
        stop <= 4'h0;
        repeat (400) @(posedge clk);
        chk("sel back", 1, sel);
        wr(8'h00, 32'h0);
        repeat (10) @(posedge clk);
        chk("lock off", 0, locked);
        wr(8'h14, 32'h8000_0001);
        wr(8'h18, 32'h0000_03ff);
        chk("fb divider", {10'h3ff, 32'h8000_0001}, fbdiv);
        wr(8'h24, 32'h0000_0a0c);
        chk("fb shift", 21, fbsh);
        chk("int divide", 10, vco_integer_divide);
        wr(8'h24, 32'h28);
        chk("fb clamp", 0, fbsh);
        wr(8'h00, 32'h3);
        chk("frac 16", 41'h100_0000_0000, fratio);
        wr(8'h2c, 32'h50);
        chk("frac div", {9'h050, 32'h0}, fratio);
        wr(8'h38, 32'h10);
        chk("frac shift", 20, frsh);
        wr(8'h00, 32'h1);
        chk("frac off", 0, {frac_on, fratio});
        wr(8'h1c, 32'h1234_5678);
        wr(8'h34, 32'hed);
        chk("fb rem den", {32'h1234_5678, 32'h1}, {fbrem, fbden});
        chk("fr rem den", {32'h0, 32'hed}, {frrem, frden});
        rd(8'h3c);
        chk("bad read", {2'b10, 32'h0}, {resp, rdata});
        wr(8'h0c, 32'h0);
        chk("status write", 2'b10, resp);
        summarize();
    end
endmodule // pll_cfg_tb_top
